// [core/ebe_ctrl.v]
// Endian select and burst ROM configuration registers with external byte lane sequencer.
// Assumes an Avalon-MM master on ref_clk_i and a single external bus cycle per step request.
// Functional notes
// RULE1: Areas 7 to 2 each have endian bit
// RULE2: Internal big endian; little only externally
// RULE3: Software keeps code and stack big endian
// RULE4: Endian low bits read zero, reset zero
// RULE5: Area 0 burst words four to 32
// RULE6: Area 1 burst ROM select, reset zero
// RULE7: Software clears byte-control SRAM bit first
// RULE8: Area 1 burst cycle length code plus one
// RULE9: Area 1 burst words four to 32
// RULE10: Little 8-bit space sends bytes LSB first
// RULE11: 16-bit space uses both byte lanes
// RULE12: Big endian even byte upper lane
// RULE13: Little endian even byte lower lane
// RULE14: Areas 0 and 1 always big endian
`timescale 1ns/1ps
`include "ebe_regs.vh"
module ebe_ctrl (
    // Clock and reset
    input  wire        ref_clk_i,
    input  wire        reset_n_i,
    // Avalon-MM slave
    input  wire [3:0]  avs_address_i,
    input  wire        avs_read_i,
    input  wire        avs_write_i,
    input  wire [31:0] avs_writedata_i,
    input  wire [3:0]  avs_byteenable_i,
    output reg  [31:0] avs_readdata_o,
    output reg         avs_waitrequest_o,
    // External access request
    input  wire        acc_start_i,
    input  wire [2:0]  acc_area_i,
    input  wire [1:0]  acc_size_i,
    input  wire        acc_addr0_i,
    input  wire        acc_bus16_i,
    input  wire [31:0] acc_wdata_i,
    output reg         acc_busy_o,
    // External data bus
    output reg  [15:0] ext_data_o,
    output reg         ext_upper_en_o,
    output reg         ext_lower_en_o,
    output reg         ext_cycle_o,
    // Burst ROM configuration
    output reg  [5:0]  a0_burst_max_words_o,
    output reg         a1_burst_rom_sel_o,
    output reg  [3:0]  a1_burst_cycles_o,
    output reg  [5:0]  a1_burst_max_words_o
);
    localparam ST_IDLE = 2'b01;
    localparam ST_RUN  = 2'b10;

    reg  [7:0]  area_endian_select;
    reg  [15:0] burst_rom_config;
    reg  [7:0]  sram_iface_control;
    reg         ack;
    reg  [1:0]  state;
    reg  [1:0]  step;
    reg         cur_little;
    reg         cur_bus16;
    reg  [1:0]  cur_size;
    reg         cur_addr0;
    reg  [31:0] cur_wdata;
    reg  [31:0] next_readdata;
    wire        access;
    wire        hit_endian;
    wire        hit_burst;
    wire        hit_sram;
    reg         area_little;
    wire [15:0] lane_data;
    wire        lane_upper;
    wire        lane_lower;
    wire [1:0]  lane_count;
    wire [15:0] burst_wmask;

    // Named register fields
    wire        area7_little_sel;
    wire        area6_little_sel;
    wire        area5_little_sel;
    wire        area4_little_sel;
    wire        area3_little_sel;
    wire        area2_little_sel;
    wire        a0_burst_words_hi;
    wire        a0_burst_words_lo;
    wire        a1_burst_rom_sel;
    wire        a1_burst_len_b2;
    wire        a1_burst_len_b1;
    wire        a1_burst_len_b0;
    wire        a1_burst_words_hi;
    wire        a1_burst_words_lo;
    // Write strobes
    wire        wr_endian;
    wire        wr_burst_lo;
    wire        wr_burst_hi;
    wire        wr_sram;
    // Decoded burst values
    reg  [5:0]  next_a0_words;
    reg  [5:0]  next_a1_words;
    reg  [3:0]  next_a1_cycles;

    assign access     = (avs_read_i | avs_write_i) & ~ack;
    assign hit_endian = avs_address_i == `EBE_OFS_ENDIAN;
    assign hit_burst  = avs_address_i == `EBE_OFS_BURST;
    assign hit_sram   = avs_address_i == `EBE_OFS_SRAMCTL;
    // Write strobes, one per register byte, each gated by its byte enable
    assign burst_wmask = `EBE_BURST_WMASK;
    assign wr_endian   = access & avs_write_i & hit_endian & avs_byteenable_i[0];
    assign wr_burst_lo = access & avs_write_i & hit_burst & avs_byteenable_i[0];
    assign wr_burst_hi = access & avs_write_i & hit_burst & avs_byteenable_i[1];
    assign wr_sram     = access & avs_write_i & hit_sram & avs_byteenable_i[0];

    // Field views of the stored registers
    assign area7_little_sel  = area_endian_select[7];                           // [RULE1]
    assign area6_little_sel  = area_endian_select[6];
    assign area5_little_sel  = area_endian_select[5];
    assign area4_little_sel  = area_endian_select[4];
    assign area3_little_sel  = area_endian_select[3];
    assign area2_little_sel  = area_endian_select[2];
    assign a0_burst_words_hi = burst_rom_config[`EBE_A0_WORDS_LSB+1];
    assign a0_burst_words_lo = burst_rom_config[`EBE_A0_WORDS_LSB];
    assign a1_burst_rom_sel  = burst_rom_config[`EBE_A1_ROM_BIT];
    assign a1_burst_len_b2   = burst_rom_config[`EBE_A1_LEN_LSB+2];
    assign a1_burst_len_b1   = burst_rom_config[`EBE_A1_LEN_LSB+1];
    assign a1_burst_len_b0   = burst_rom_config[`EBE_A1_LEN_LSB];
    assign a1_burst_words_hi = burst_rom_config[`EBE_A1_WORDS_LSB+1];
    assign a1_burst_words_lo = burst_rom_config[`EBE_A1_WORDS_LSB];

    // Areas without a select bit stay big endian
    always @* begin
        area_little = 1'b0;
        case (acc_area_i)
            3'h7:    area_little = area7_little_sel;                            // [RULE1]
            3'h6:    area_little = area6_little_sel;
            3'h5:    area_little = area5_little_sel;
            3'h4:    area_little = area4_little_sel;
            3'h3:    area_little = area3_little_sel;
            3'h2:    area_little = area2_little_sel;
            default: area_little = 1'b0;                                        // [RULE14]
        endcase
    end

    // Burst words double per code step; cycles are code plus one
    always @* begin
        next_a0_words  = 6'h04;
        next_a1_words  = 6'h04;
        next_a1_cycles = {1'b0, a1_burst_len_b2, a1_burst_len_b1, a1_burst_len_b0} + 4'h1; // [RULE8]
        case ({a0_burst_words_hi, a0_burst_words_lo})
            2'h0:    next_a0_words = 6'h04;                                     // [RULE5]
            2'h1:    next_a0_words = 6'h08;
            2'h2:    next_a0_words = 6'h10;
            default: next_a0_words = 6'h20;
        endcase
        case ({a1_burst_words_hi, a1_burst_words_lo})
            2'h0:    next_a1_words = 6'h04;                                     // [RULE9]
            2'h1:    next_a1_words = 6'h08;
            2'h2:    next_a1_words = 6'h10;
            default: next_a1_words = 6'h20;
        endcase
    end

    always @* begin
        next_readdata = 32'h0000_0000;
        case (avs_address_i)
            `EBE_OFS_ENDIAN: begin
                next_readdata[7:0] = {area7_little_sel, area6_little_sel, area5_little_sel,
                                      area4_little_sel, area3_little_sel, area2_little_sel, 2'b00}; // [RULE4]
            end
            `EBE_OFS_BURST: begin
                next_readdata[15:0] = burst_rom_config & burst_wmask;
            end
            `EBE_OFS_SRAMCTL: begin
                next_readdata[7:0] = sram_iface_control;
            end
            default: begin
                next_readdata = 32'h0000_0000;
            end
        endcase
    end

    // One wait state per access; unmapped reads return zero, writes dropped
    always @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ack               <= 1'b0;
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o    <= 32'h0000_0000;
        end else begin
            ack               <= access;
            avs_waitrequest_o <= ~access;
            if (access && avs_read_i) begin
                avs_readdata_o <= next_readdata;
            end
        end
    end

    // Register storage
    always @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            area_endian_select <= `EBE_ENDIAN_RST;                               // [RULE4]
            burst_rom_config   <= `EBE_BURST_RST;                                // [RULE6]
            sram_iface_control <= `EBE_SRAMCTL_RST;
        end else begin
            if (wr_endian) begin
                area_endian_select <= avs_writedata_i[7:0] & `EBE_ENDIAN_WMASK; // [RULE4]
            end
            if (wr_burst_lo) begin
                burst_rom_config[7:0] <= avs_writedata_i[7:0] & burst_wmask[7:0];
            end
            if (wr_burst_hi) begin
                burst_rom_config[15:8] <= avs_writedata_i[15:8] & burst_wmask[15:8];
            end
            if (wr_sram) begin
                sram_iface_control <= avs_writedata_i[7:0];
            end
        end
    end

    // Decoded burst configuration
    always @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            a0_burst_max_words_o <= 6'h04;
            a1_burst_rom_sel_o   <= 1'b0;
            a1_burst_cycles_o    <= 4'h1;
            a1_burst_max_words_o <= 6'h04;
        end else begin
            a0_burst_max_words_o <= next_a0_words;                              // [RULE5]
            a1_burst_rom_sel_o   <= a1_burst_rom_sel;                           // [RULE6]
            a1_burst_cycles_o    <= next_a1_cycles;                             // [RULE8]
            a1_burst_max_words_o <= next_a1_words;                              // [RULE9]
        end
    end

    ebe_lane_steer u_lane (
        .little_i   (cur_little),
        .bus16_i    (cur_bus16),
        .size_i     (cur_size),
        .addr0_i    (cur_addr0),
        .step_i     (step),
        .wdata_i    (cur_wdata),
        .bus_data_o (lane_data),
        .upper_en_o (lane_upper),
        .lower_en_o (lane_lower),
        .count_o    (lane_count)
    );

    // Access capture while idle
    always @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cur_little <= 1'b0;
            cur_bus16  <= 1'b0;
            cur_size   <= 2'h0;
            cur_addr0  <= 1'b0;
            cur_wdata  <= 32'h0000_0000;
        end else if ((state == ST_IDLE) && acc_start_i) begin
            cur_little <= area_little;                                          // [RULE2]
            cur_bus16  <= acc_bus16_i;
            cur_size   <= acc_size_i;
            cur_addr0  <= acc_addr0_i;
            cur_wdata  <= acc_wdata_i;
        end
    end

    // Bus cycle sequencer: one external cycle per clock
    always @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state          <= ST_IDLE;
            step           <= 2'h0;
            acc_busy_o     <= 1'b0;
            ext_data_o     <= 16'h0000;
            ext_upper_en_o <= 1'b0;
            ext_lower_en_o <= 1'b0;
            ext_cycle_o    <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    ext_cycle_o    <= 1'b0;
                    ext_upper_en_o <= 1'b0;
                    ext_lower_en_o <= 1'b0;
                    if (acc_start_i) begin
                        step       <= 2'h0;
                        acc_busy_o <= 1'b1;
                        state      <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    ext_cycle_o    <= 1'b1;
                    ext_data_o     <= lane_data;
                    ext_upper_en_o <= lane_upper;
                    ext_lower_en_o <= lane_lower;
                    if (step == lane_count) begin                               // [RULE10]
                        acc_busy_o <= 1'b0;
                        state      <= ST_IDLE;
                    end else begin
                        step <= step + 2'h1;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end
endmodule

// [core/ebe_regs.vh]
// Register offsets, field positions and reset values of the endian and burst ROM control block.
// Included by ebe_ctrl, the checker and the testbench; defines only.
`ifndef EBE_REGS_VH
`define EBE_REGS_VH

`define EBE_OFS_ENDIAN      4'h0
`define EBE_OFS_BURST       4'h4
`define EBE_OFS_SRAMCTL     4'h8

`define EBE_ENDIAN_RST      8'h00
`define EBE_ENDIAN_WMASK    8'hfc
`define EBE_BURST_RST       16'h0000
`define EBE_BURST_WMASK     16'h03f3
`define EBE_SRAMCTL_RST     8'h00

`define EBE_A0_WORDS_LSB    8
`define EBE_A1_ROM_BIT      7
`define EBE_A1_LEN_LSB      4
`define EBE_A1_WORDS_LSB    0
`define EBE_A1_BYTECTL_BIT  1

`define EBE_SIZE_BYTE       2'h0
`define EBE_SIZE_WORD       2'h1
`define EBE_SIZE_LONG       2'h2

`endif

// [core/ebe_lane_steer.v]
// Byte lane steering for one external bus cycle.
// Assumes the access size, area endian and bus width are stable while the cycle is stepped.
`timescale 1ns/1ps
module ebe_lane_steer (
    // Access description
    input  wire        little_i,
    input  wire        bus16_i,
    input  wire [1:0]  size_i,
    input  wire        addr0_i,
    input  wire [1:0]  step_i,
    input  wire [31:0] wdata_i,
    // Lane result
    output reg  [15:0] bus_data_o,
    output reg         upper_en_o,
    output reg         lower_en_o,
    output reg  [1:0]  count_o
);
    reg [7:0] sel_byte;
    reg [1:0] idx;

    always @* begin
        idx        = 2'h0;
        sel_byte   = 8'h00;
        bus_data_o = 16'h0000;
        upper_en_o = 1'b0;
        lower_en_o = 1'b0;
        count_o    = 2'h0;
        if (!bus16_i) begin
            // 8-bit space: one byte per cycle
            case (size_i)
                `EBE_SIZE_BYTE: count_o = 2'h0;
                `EBE_SIZE_WORD: count_o = 2'h1;
                default:        count_o = 2'h3;
            endcase
            if (little_i) begin
                idx = step_i;                                  // [RULE10]
            end else begin
                idx = count_o - step_i;                        // [RULE2]
            end
            case (idx)
                2'h0:    sel_byte = wdata_i[7:0];
                2'h1:    sel_byte = wdata_i[15:8];
                2'h2:    sel_byte = wdata_i[23:16];
                default: sel_byte = wdata_i[31:24];
            endcase
            bus_data_o = {8'h00, sel_byte};
            lower_en_o = 1'b1;
        end else begin
            // 16-bit space: one byte or one word per cycle [RULE11]
            if (size_i == `EBE_SIZE_BYTE) begin
                count_o = 2'h0;
                if (addr0_i ^ little_i) begin
                    lower_en_o = 1'b1;                         // [RULE12] [RULE13]
                    bus_data_o = {8'h00, wdata_i[7:0]};
                end else begin
                    upper_en_o = 1'b1;                         // [RULE12] [RULE13]
                    bus_data_o = {wdata_i[7:0], 8'h00};
                end
            end else begin
                count_o    = (size_i == `EBE_SIZE_WORD) ? 2'h0 : 2'h1;
                upper_en_o = 1'b1;
                lower_en_o = 1'b1;
                // Big endian sends the upper half first, little the lower half
                if (size_i == `EBE_SIZE_WORD) begin
                    idx = 2'h0;
                end else if (little_i) begin
                    idx = step_i;                                      // [RULE13]
                end else begin
                    idx = 2'h1 - step_i;                               // [RULE12]
                end
                if (idx == 2'h0) begin
                    bus_data_o = wdata_i[15:0];
                end else begin
                    bus_data_o = wdata_i[31:16];
                end
            end
        end
    end
endmodule

// [verification/ebe_mem_model.sv]
// Far-side memory model: collects the bytes and lanes of each external bus cycle.
// Assumes one bus cycle per clock while cycle_i is high.
`timescale 1ns/1ps
module ebe_mem_model (
    // Bus side
    input  wire        ref_clk_i,
    input  wire        clear_i,
    input  wire [15:0] data_i,
    input  wire        upper_i,
    input  wire        lower_i,
    input  wire        cycle_i,
    // Collected data
    output reg  [31:0] got_o,
    output reg  [3:0]  cnt_o,
    output reg  [1:0]  lanes_o
);
    always @(posedge ref_clk_i) begin
        if (clear_i) begin
            got_o <= 32'h0;
            cnt_o <= 4'h0;
        end else if (cycle_i) begin
            cnt_o <= cnt_o + 4'h1;
            lanes_o <= {upper_i, lower_i};
            if (upper_i && lower_i)
                got_o <= {got_o[15:0], data_i};
            else
                got_o <= {got_o[23:0], upper_i ? data_i[15:8] : data_i[7:0]};
        end
    end
endmodule

// [verification/ebe_ctrl_chk.sv]
// Checker: register readback, burst decode and byte lane assertions.
// Assumes binding to ebe_ctrl; burst writes carry all byte enables.
`timescale 1ns/1ps
`include "ebe_regs.vh"
module ebe_chk (
    // Watched design ports
    input wire        ref_clk_i,
    input wire        reset_n_i,
    input wire [3:0]  avs_address_i,
    input wire        avs_read_i,
    input wire        avs_write_i,
    input wire [31:0] avs_writedata_i,
    input wire [31:0] avs_readdata_o,
    input wire        avs_waitrequest_o,
    input wire        acc_start_i,
    input wire [2:0]  acc_area_i,
    input wire [1:0]  acc_size_i,
    input wire        acc_addr0_i,
    input wire        acc_bus16_i,
    input wire        acc_busy_o,
    input wire        ext_upper_en_o,
    input wire        ext_lower_en_o,
    input wire        ext_cycle_o,
    input wire [5:0]  a0_burst_max_words_o,
    input wire        a1_burst_rom_sel_o,
    input wire [3:0]  a1_burst_cycles_o,
    input wire [5:0]  a1_burst_max_words_o
);
    reg  [7:0] endian;
    reg  [9:0] lw;
    reg  [1:0] csz;
    reg        cb16;
    reg        ca0;
    reg        clit;
    wire       wr_ack = avs_write_i && !avs_waitrequest_o;
    wire       b16b   = ext_cycle_o && cb16 && csz == `EBE_SIZE_BYTE;
    // Shadow of endian bits, last burst write, current access
    always @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i)
            endian <= 8'h00;
        else if (wr_ack && avs_address_i == `EBE_OFS_ENDIAN)
            endian <= avs_writedata_i[7:0] & `EBE_ENDIAN_WMASK;
    end
    always @(posedge ref_clk_i) begin
        if (wr_ack && avs_address_i == `EBE_OFS_BURST)
            lw <= avs_writedata_i[9:0];
        if (acc_start_i && !acc_busy_o && !ext_cycle_o) begin
            csz  <= acc_size_i;
            cb16 <= acc_bus16_i;
            ca0  <= acc_addr0_i;
            clit <= acc_area_i >= 3'h2 && endian[acc_area_i];
        end
    end
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);
    sequence s_bwr; wr_ack && avs_address_i == `EBE_OFS_BURST; endsequence
    sequence s_go; acc_start_i && !acc_busy_o && !ext_cycle_o; endsequence
    property p_rdz;
        avs_read_i && !avs_waitrequest_o && avs_address_i == `EBE_OFS_ENDIAN |-> avs_readdata_o[1:0] == 2'h0;
    endproperty
    a_rdz: assert property (p_rdz) else $error("endian low bits not zero");
    property p_len; s_bwr |-> ##2 a1_burst_cycles_o == {1'b0, lw[6:4]} + 4'h1; endproperty
    a_len: assert property (p_len) else $error("burst cycle count wrong");
    property p_rom; s_bwr |-> ##2 a1_burst_rom_sel_o == lw[7]; endproperty
    a_rom: assert property (p_rom) else $error("burst rom select wrong");
    property p_w0; s_bwr |-> ##2 a0_burst_max_words_o == 6'h04 << lw[9:8]; endproperty
    a_w0: assert property (p_w0) else $error("area 0 words wrong");
    property p_w1; s_bwr |-> ##2 a1_burst_max_words_o == 6'h04 << lw[1:0]; endproperty
    a_w1: assert property (p_w1) else $error("area 1 words wrong");
    property p_go; s_go |-> ##[1:3] ext_cycle_o; endproperty
    a_go: assert property (p_go) else $error("bus cycle late");
    property p_big; b16b && !clit |-> ext_upper_en_o == !ca0 && ext_lower_en_o == ca0; endproperty
    a_big: assert property (p_big) else $error("big endian lane wrong");
    property p_lit; b16b && clit |-> ext_upper_en_o == ca0 && ext_lower_en_o == !ca0; endproperty
    a_lit: assert property (p_lit) else $error("little endian lane wrong");
    property p_w16; ext_cycle_o && cb16 && csz != `EBE_SIZE_BYTE |-> ext_upper_en_o && ext_lower_en_o; endproperty
    a_w16: assert property (p_w16) else $error("wide cycle lane missing");
endmodule

// [verification/tb.sv]
// Testbench: register, burst decode and lane steering tests.
// Assumes ebe_mem_model on the external bus and ebe_chk bound below.
`timescale 1ns/1ps
`include "ebe_regs.vh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin miscompares++; $display("mismatch %s exp %h got %h", n, e, g); end end
module tb;
    reg         ref_clk_i = 1'b0;
    reg         reset_n_i = 1'b0;
    reg  [3:0]  avs_address_i = 4'h0;
    reg         avs_read_i = 1'b0;
    reg         avs_write_i = 1'b0;
    reg  [31:0] avs_writedata_i = 32'h0;
    reg  [3:0]  avs_byteenable_i = 4'hf;
    reg         acc_start_i = 1'b0;
    reg  [2:0]  acc_area_i = 3'h0;
    reg  [1:0]  acc_size_i = 2'h0;
    reg         acc_addr0_i = 1'b0;
    reg         acc_bus16_i = 1'b0;
    reg  [31:0] acc_wdata_i = 32'h44332211;
    reg         mem_clear = 1'b0;
    reg  [31:0] rd_val;
    wire [31:0] avs_readdata_o, mem_got;
    wire [15:0] ext_data_o;
    wire        avs_waitrequest_o, acc_busy_o, ext_upper_en_o, ext_lower_en_o, ext_cycle_o, a1_burst_rom_sel_o;
    wire [5:0]  a0_burst_max_words_o, a1_burst_max_words_o;
    wire [3:0]  a1_burst_cycles_o, mem_cnt;
    wire [1:0]  mem_lanes;
    integer     miscompares = 0;
    integer     tests_run = 0;
    integer     j;
    always #12.5 ref_clk_i = ~ref_clk_i;
    ebe_ctrl i_ebe_ctrl (.*);
    ebe_mem_model i_ebe_mem_model (.ref_clk_i(ref_clk_i), .clear_i(mem_clear), .data_i(ext_data_o),
        .upper_i(ext_upper_en_o), .lower_i(ext_lower_en_o), .cycle_i(ext_cycle_o),
        .got_o(mem_got), .cnt_o(mem_cnt), .lanes_o(mem_lanes));
    task bus(input wr, input [3:0] a, input [31:0] d);
        begin
            @(posedge ref_clk_i);
            avs_address_i <= a;
            avs_writedata_i <= d;
            avs_write_i <= wr;
            avs_read_i <= !wr;
            do @(posedge ref_clk_i); while (avs_waitrequest_o !== 1'b0);
            rd_val = avs_readdata_o;
            avs_write_i <= 1'b0;
            avs_read_i <= 1'b0;
        end
    endtask
    task rchk(input [3:0] a, input [31:0] e);
        begin
            bus(1'b0, a, 32'h0);
            `CHK("readdata", e, rd_val)
        end
    endtask
    task acc(input [2:0] ar, input [1:0] sz, input b16, input a0, input [3:0] ec, input [31:0] eg, input [1:0] el);
        begin
            @(posedge ref_clk_i);
            acc_area_i <= ar;
            acc_size_i <= sz;
            acc_bus16_i <= b16;
            acc_addr0_i <= a0;
            acc_start_i <= 1'b1;
            mem_clear <= 1'b1;
            @(posedge ref_clk_i);
            acc_start_i <= 1'b0;
            mem_clear <= 1'b0;
            do @(posedge ref_clk_i); while (acc_busy_o !== 1'b0 || ext_cycle_o !== 1'b0);
            `CHK("cycles", ec, mem_cnt)
            `CHK("data", eg, mem_got)
            if (b16)
                `CHK("lanes", el, mem_lanes)
        end
    endtask
    task print_verdict;
        begin
            $display("checks %0d mismatches %0d", tests_run, miscompares);
            if (miscompares == 0 && tests_run > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask
    initial begin
        repeat (5000) @(posedge ref_clk_i);
        miscompares++;
        print_verdict;
    end
    initial begin
        repeat (12) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
        rchk(`EBE_OFS_ENDIAN, 32'h0);
        rchk(`EBE_OFS_BURST, 32'h0);
        bus(1'b1, `EBE_OFS_ENDIAN, 32'hff);
        rchk(`EBE_OFS_ENDIAN, 32'hfc);
        bus(1'b1, 4'hc, 32'hff);
        rchk(4'hc, 32'h0);
        bus(1'b1, `EBE_OFS_BURST, 32'hffff);
        rchk(`EBE_OFS_BURST, 32'h3f3);
        bus(1'b1, `EBE_OFS_SRAMCTL, 32'h0);
        for (j = 0; j < 8; j++) begin
            bus(1'b1, `EBE_OFS_BURST, {22'h0, j[1:0], j[0], j[2:0], 2'h0, j[1:0]});
            repeat (2) @(posedge ref_clk_i);
            `CHK("a0_words", 6'h04 << j[1:0], a0_burst_max_words_o)
            `CHK("a1_cycles", j[3:0] + 4'h1, a1_burst_cycles_o)
            `CHK("a1_rom", j[0], a1_burst_rom_sel_o)
            `CHK("a1_words", 6'h04 << j[1:0], a1_burst_max_words_o)
        end
        // Area 3 big, areas 2 and 4 to 7 little
        bus(1'b1, `EBE_OFS_ENDIAN, 32'hf4);
        acc(3'h2, `EBE_SIZE_LONG, 1'b0, 1'b0, 4'h4, 32'h11223344, 2'h0);
        acc(3'h2, `EBE_SIZE_WORD, 1'b0, 1'b0, 4'h2, 32'h00001122, 2'h0);
        acc(3'h2, `EBE_SIZE_BYTE, 1'b0, 1'b0, 4'h1, 32'h00000011, 2'h0);
        acc(3'h5, `EBE_SIZE_LONG, 1'b0, 1'b0, 4'h4, 32'h11223344, 2'h0);
        acc(3'h3, `EBE_SIZE_LONG, 1'b0, 1'b0, 4'h4, 32'h44332211, 2'h0);
        acc(3'h0, `EBE_SIZE_LONG, 1'b0, 1'b0, 4'h4, 32'h44332211, 2'h0);
        acc(3'h1, `EBE_SIZE_BYTE, 1'b1, 1'b0, 4'h1, 32'h00000011, 2'h2);
        acc(3'h2, `EBE_SIZE_BYTE, 1'b1, 1'b0, 4'h1, 32'h00000011, 2'h1);
        acc(3'h2, `EBE_SIZE_BYTE, 1'b1, 1'b1, 4'h1, 32'h00000011, 2'h2);
        acc(3'h3, `EBE_SIZE_BYTE, 1'b1, 1'b0, 4'h1, 32'h00000011, 2'h2);
        acc(3'h3, `EBE_SIZE_BYTE, 1'b1, 1'b1, 4'h1, 32'h00000011, 2'h1);
        acc(3'h3, `EBE_SIZE_WORD, 1'b1, 1'b0, 4'h1, 32'h00002211, 2'h3);
        acc(3'h2, `EBE_SIZE_WORD, 1'b1, 1'b0, 4'h1, 32'h00002211, 2'h3);
        acc(3'h3, `EBE_SIZE_LONG, 1'b1, 1'b0, 4'h2, 32'h44332211, 2'h3);
        acc(3'h2, `EBE_SIZE_LONG, 1'b1, 1'b0, 4'h2, 32'h22114433, 2'h3);
        print_verdict;
    end
endmodule
bind ebe_ctrl ebe_chk i_ebe_chk (.*);
